//--- verilog/mohc_top.sv
/*
 * Auto-mode supervisor: speed overrides, handwheel override, operator
 * stops and external hold knob / start / pause inputs.
 * Assumes block progress arrives as one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none
module mohc_top
   import mohc_pkg::*;
#(
   parameter int DEB    = DEB_CYCLES,
   parameter int HW_WIN = HW_WIN_CYCLES,
   parameter int SPD_W  = 16
)
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Configuration
   input  wire logic              handwheel_override_enable,
   input  wire logic              handwheel_method_select,
   input  wire logic              hold_knob_enable,
   input  wire logic              ext_start_pause_enable,
   input  wire logic [SPD_W-1:0]  axis_z_rapid_speed,
   input  wire logic [SPD_W-1:0]  axis_x_rapid_speed,
   input  wire logic [SPD_W-1:0]  axis_y_rapid_speed,
   // Operator panel, one-cycle pulses except the auto_mode, estop and single_mode levels
   input  wire logic              auto_mode,
   input  wire logic              estop,
   input  wire logic              single_mode,
   input  wire logic              key_start,
   input  wire logic              key_pause,
   input  wire logic              key_escape,
   input  wire logic              key_reset,
   input  wire logic              key_cycle_stop,
   input  wire logic              key_handwheel,
   input  wire logic              key_spindle_on,
   input  wire logic              key_spindle_off,
   input  wire logic              feed_ovr_up,
   input  wire logic              feed_ovr_down,
   input  wire logic              rapid_ovr_up,
   input  wire logic              rapid_ovr_down,
   // Handwheel detents
   input  wire logic              handwheel_detent,
   input  wire logic              handwheel_cw,
   // Block sequencer
   input  wire logic              block_done,
   input  wire logic              cycle_step_done,
   input  wire logic              cycle_end_done,
   input  wire logic              program_end,
   input  wire logic              thread_block,
   input  wire logic              prog_spindle_on,
   input  wire logic              prog_spindle_off,
   input  wire logic [SPD_W-1:0]  prog_feed,
   input  wire logic [SPD_W-1:0]  spindle_feed,
   // Machine pins, active low
   input  wire logic              ext_cycle_start_in_n,
   input  wire logic              ext_cycle_pause_in_n,
   input  wire logic              hold_knob_input_a_n,
   input  wire logic              hold_knob_input_b_n,
   // Motion and spindle command path
   output logic [SPD_W-1:0]       feed_speed,
   output logic [SPD_W-1:0]       rapid_z_speed,
   output logic [SPD_W-1:0]       rapid_x_speed,
   output logic [SPD_W-1:0]       rapid_y_speed,
   output logic                   axis_allow,
   output logic                   block_allow,
   output logic                   spindle_run,
   output logic                   block_ptr_reset,
   // Status
   output logic [5:0]             run_state,
   output logic [3:0]             feed_ovr_step,
   output logic [1:0]             rapid_ovr_code,
   output logic [6:0]             handwheel_pct,
   output logic                   handwheel_mode,
   output logic                   zero_ovr_prompt,
   output logic                   cycle_stop_armed,
   output logic                   ext_alarm
);
   localparam int WW = $clog2(HW_WIN + 1);

   typedef struct packed {
      mohc_state_t       st;
      logic [3:0]        fo;
      logic [1:0]        ro;
      logic [6:0]        hw;
      logic              hw_mode;
      logic              hw_held;
      logic [WW-1:0]     win;
      logic [6:0]        cw_cnt;
      logic              ccw_seen;
      logic              cstop_arm;
      logic              spin_on;
      logic              ext_start_q;
      logic              ext_pause_q;
      logic              auto_q;
      logic              alarm;
      logic              ptr_rst;
      logic              zero_prompt;
      logic              ax_allow;
      logic              blk_allow;
      logic              spin_run;
      logic [SPD_W-1:0]  feed;
      logic [SPD_W-1:0]  rz;
      logic [SPD_W-1:0]  rx;
      logic [SPD_W-1:0]  ry;
   } mohc_top_t;

   mohc_top_t r;
   mohc_top_t next_r;

   mohc_in_if #(.N(IN_COUNT)) pins ();

   if (SPD_W < 1 || SPD_W > 16 || HW_WIN < 2)
   begin : g_bad
      $error("mohc_top: bad SPD_W or HW_WIN");
   end

   mohc_sync #(
      .N     (IN_COUNT),
      .DEB   (DEB)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_n   ({hold_knob_input_b_n, hold_knob_input_a_n,
                 ext_cycle_pause_in_n, ext_cycle_start_in_n}),
      .outp    (pins.src)
   );

   // Scales a speed by a percentage, optionally by the handwheel too
   function automatic logic [SPD_W-1:0] scale(input logic [SPD_W-1:0] s,
                                              input logic [7:0] pct,
                                              input logic [6:0] hw,
                                              input logic use_hw);
      logic [31:0] p;
      p = 32'(s) * 32'(pct);
      if (use_hw)
         p = 32'(p * 32'(hw)) / PCT2_DIV;
      else
         p = p / PCT_DIV;
      return p[SPD_W-1:0];
   endfunction

   logic        knob2;
   logic        knob3;
   logic        ext_start;
   logic        ext_pause;
   logic        start_req;
   logic        pause_req;
   logic        quit_req;
   logic        stopped;
   logic        hw_act;
   logic        win_end;
   logic [7:0]  fo_pct;
   logic [7:0]  ro_pct;
   logic [6:0]  step;

   always_comb
   begin
      // Knob ignored unless enabled; input b wins over a
      knob3     = hold_knob_enable && pins.asserted[IN_KNOB_B];
      knob2     = hold_knob_enable && pins.asserted[IN_KNOB_A] && !knob3;
      ext_start = ext_start_pause_enable && pins.asserted[IN_START];
      ext_pause = ext_start_pause_enable && pins.asserted[IN_PAUSE];
      start_req = key_start || (ext_start && !r.ext_start_q);
      pause_req = key_pause || (ext_pause && !r.ext_pause_q);
      quit_req  = key_escape || key_reset;
      stopped   = r.st == MOHC_PAUSE || r.st == MOHC_SSTOP || r.st == MOHC_CSTOP;
      hw_act    = r.hw_mode && handwheel_override_enable;
      win_end   = r.win == WW'(HW_WIN - 1);
      fo_pct    = 8'(r.fo * FEED_STEP_PCT);
      ro_pct    = 8'(({6'h00, r.ro} + 8'h01) * 8'h19);
      step      = (r.cw_cnt > HW_STEP_MAX) ? HW_STEP_MAX : r.cw_cnt;

      next_r             = r;
      next_r.ptr_rst     = 1'b0;
      next_r.ext_start_q = ext_start;
      next_r.ext_pause_q = ext_pause;
      next_r.auto_q      = auto_mode;

      // Overrides respond in every state
      if (feed_ovr_up && r.fo != FEED_STEP_MAX)
         next_r.fo = r.fo + 4'h1;
      else if (feed_ovr_down && r.fo != 4'h0)
         next_r.fo = r.fo - 4'h1;
      if (rapid_ovr_up && r.ro != RAPID_MAX)
         next_r.ro = r.ro + 2'h1;
      else if (rapid_ovr_down && r.ro != 2'h0)
         next_r.ro = r.ro - 2'h1;

      // Pins held at entry to auto; reset key clears
      if (auto_mode && !r.auto_q && ext_start_pause_enable &&
          (pins.asserted[IN_START] || pins.asserted[IN_PAUSE]))
         next_r.alarm = 1'b1;
      else if (key_reset)
         next_r.alarm = 1'b0;

      if (key_cycle_stop && r.st == MOHC_RUN)
         next_r.cstop_arm = 1'b1;

      case (r.st)
         MOHC_IDLE:
         begin
            if (key_spindle_on && !knob3)
               next_r.spin_on = 1'b1;
            else if (key_spindle_off)
               next_r.spin_on = 1'b0;
            if (start_req && auto_mode && !r.alarm)
               next_r.st = MOHC_RUN;
         end
         MOHC_RUN:
         begin
            if (quit_req && (knob2 || knob3))
            begin
               next_r.st        = MOHC_IDLE;
               next_r.spin_on   = 1'b0;
               next_r.ptr_rst   = 1'b1;
               next_r.cstop_arm = 1'b0;
            end
            else if (program_end)
            begin
               next_r.st        = MOHC_IDLE;
               next_r.hw_mode   = 1'b0;
               next_r.cstop_arm = 1'b0;
            end
            else if (pause_req && !thread_block)
               next_r.st = MOHC_PAUSE;
            else if (r.cstop_arm && cycle_end_done)
               next_r.st = MOHC_CSTOP;
            else if (single_mode && (block_done || cycle_step_done))
               next_r.st = MOHC_SSTOP;
            if (prog_spindle_on && !knob3)
               next_r.spin_on = 1'b1;
            else if (prog_spindle_off)
               next_r.spin_on = 1'b0;
         end
         MOHC_PAUSE, MOHC_SSTOP, MOHC_CSTOP:
         begin
            if (quit_req)
            begin
               next_r.st        = MOHC_IDLE;
               next_r.ptr_rst   = 1'b1;
               next_r.cstop_arm = 1'b0;
            end
            else if (start_req)
            begin
               next_r.st = MOHC_RUN;
               if (r.st == MOHC_CSTOP)
                  next_r.cstop_arm = 1'b0;
            end
         end
         MOHC_ESTOP:
         begin
            // Start is deliberately not a way out
            if (!estop && quit_req)
            begin
               next_r.st      = MOHC_IDLE;
               next_r.ptr_rst = 1'b1;
            end
         end
         default:
            next_r.st = MOHC_IDLE;
      endcase

      if (estop)
      begin
         next_r.st        = MOHC_ESTOP;
         next_r.spin_on   = 1'b0;
         next_r.cstop_arm = 1'b0;
         next_r.hw_mode   = 1'b0;
      end

      // Entry only idle, stopped, or running with the knob at position 2 or 3
      if (key_handwheel && handwheel_override_enable && !r.hw_mode &&
          (r.st == MOHC_IDLE || stopped || (r.st == MOHC_RUN && (knob2 || knob3))))
      begin
         next_r.hw_mode  = 1'b1;
         next_r.hw       = 7'h00;
         next_r.hw_held  = 1'b0;
         next_r.win      = '0;
         next_r.cw_cnt   = 7'h00;
         next_r.ccw_seen = 1'b0;
      end
      else if (r.hw_mode && !handwheel_method_select)
      begin
         if (handwheel_detent && handwheel_cw && r.hw != HW_PCT_MAX)
            next_r.hw = r.hw + 7'h01;
         else if (handwheel_detent && !handwheel_cw && r.hw != 7'h00)
            next_r.hw = r.hw - 7'h01;
      end
      else if (r.hw_mode)
      begin
         // Detents counted per window give rotation speed
         next_r.win = win_end ? '0 : r.win + WW'(1);
         if (handwheel_detent && handwheel_cw && r.cw_cnt != HW_PCT_MAX)
            next_r.cw_cnt = r.cw_cnt + 7'h01;
         if (handwheel_detent && !handwheel_cw)
            next_r.ccw_seen = 1'b1;
         if (win_end)
         begin
            next_r.cw_cnt   = 7'h00;
            next_r.ccw_seen = 1'b0;
            if (r.cw_cnt != 7'h00)
            begin
               next_r.hw_held = 1'b0;
               next_r.hw      = (r.hw > HW_PCT_MAX - step) ? HW_PCT_MAX
                                                          : r.hw + step;
            end
            else if (r.ccw_seen)
               next_r.hw_held = 1'b1;
            else if (!r.hw_held)
               next_r.hw = 7'h00;
         end
      end

      // Registered motion outputs
      next_r.zero_prompt = r.st == MOHC_RUN && r.fo == 4'h0;
      next_r.blk_allow   = r.st == MOHC_RUN && !knob3;
      next_r.ax_allow    = r.st == MOHC_RUN && !knob2 && !knob3 &&
                           r.fo != 4'h0;
      next_r.spin_run    = r.spin_on && !knob3 && r.st != MOHC_ESTOP;
      if (thread_block)
         next_r.feed = spindle_feed;
      else
         next_r.feed = scale(prog_feed, fo_pct, r.hw, hw_act);
      next_r.rz = scale(axis_z_rapid_speed, ro_pct, r.hw, hw_act);
      next_r.rx = scale(axis_x_rapid_speed, ro_pct, r.hw, hw_act);
      next_r.ry = scale(axis_y_rapid_speed, ro_pct, r.hw, hw_act);
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         r             <= '0;
         r.st          <= MOHC_IDLE;
         r.fo          <= FEED_STEP_RST;
         r.ro          <= RAPID_RST;
      end
      else
         r <= next_r;
   end

   assign feed_speed       = r.feed;
   assign rapid_z_speed    = r.rz;
   assign rapid_x_speed    = r.rx;
   assign rapid_y_speed    = r.ry;
   assign axis_allow       = r.ax_allow;
   assign block_allow      = r.blk_allow;
   assign spindle_run      = r.spin_run;
   assign block_ptr_reset  = r.ptr_rst;
   assign run_state        = r.st;
   assign feed_ovr_step    = r.fo;
   assign rapid_ovr_code   = r.ro;
   assign handwheel_pct    = r.hw;
   assign handwheel_mode   = r.hw_mode;
   assign zero_ovr_prompt  = r.zero_prompt;
   assign cycle_stop_armed = r.cstop_arm;
   assign ext_alarm        = r.alarm;
endmodule // mohc_top
`default_nettype wire

//--- include/mohc_pkg.sv
/*
 * Constants and types shared by the override/hold supervisor.
 * Assumes a 100 MHz system clock; all times become cycle counts here.
 */
package mohc_pkg;
   localparam int          CLK_PERIOD_NS  = 10;
   // Debounce window, microseconds
   localparam int          DEB_TIME_US    = 1000;
   localparam int          DEB_CYCLES     = DEB_TIME_US * 1000 / CLK_PERIOD_NS;
   // Handwheel speed window, microseconds
   localparam int          HW_WIN_TIME_US = 10000;
   localparam int          HW_WIN_CYCLES  = HW_WIN_TIME_US * 1000 / CLK_PERIOD_NS;
   // Feed override: 16 steps of 10 percent, 100 percent after reset
   localparam logic [3:0]  FEED_STEP_RST  = 4'ha;
   localparam logic [3:0]  FEED_STEP_MAX  = 4'hf;
   localparam logic [7:0]  FEED_STEP_PCT  = 8'h0a;
   // Rapid override code n means (n+1) quarters, full speed after reset
   localparam logic [1:0]  RAPID_RST      = 2'h3;
   localparam logic [1:0]  RAPID_MAX      = 2'h3;
   // Handwheel override in percent
   localparam logic [6:0]  HW_PCT_MAX     = 7'h64;
   localparam logic [6:0]  HW_STEP_MAX    = 7'h09;
   localparam logic [31:0] PCT_DIV        = 32'h0000_0064;
   localparam logic [31:0] PCT2_DIV       = 32'h0000_2710;
   // Indices of the debounced machine inputs
   localparam int          IN_START       = 0;
   localparam int          IN_PAUSE       = 1;
   localparam int          IN_KNOB_A      = 2;
   localparam int          IN_KNOB_B      = 3;
   localparam int          IN_COUNT       = 4;

   typedef enum logic [5:0] {
      MOHC_IDLE  = 6'h01,
      MOHC_RUN   = 6'h02,
      MOHC_PAUSE = 6'h04,
      MOHC_SSTOP = 6'h08,
      MOHC_CSTOP = 6'h10,
      MOHC_ESTOP = 6'h20
   } mohc_state_t;
endpackage

//--- include/mohc_in_if.sv
/*
 * Debounced machine inputs, synchroniser to core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface mohc_in_if #(parameter int N = 4);
   logic [N-1:0] asserted;
   modport src (output asserted);
   modport snk (input asserted);
endinterface
`default_nettype wire

//--- verilog/mohc_sync.sv
/*
 * Three-stage synchroniser and debouncer for active-low machine pins.
 * Assumes pins are asynchronous to sys_clk; a released pin reads high.
 */
`timescale 1ns/100ps
`default_nettype none
module mohc_sync
   import mohc_pkg::*;
#(
   parameter int N     = IN_COUNT,
   parameter int DEB   = DEB_CYCLES,
   parameter int CW    = $clog2(DEB + 1)
)
(
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // Raw pins, active low
   input  wire logic [N-1:0]  pin_n,
   // Debounced, active high
   mohc_in_if.src             outp
);
   typedef struct packed {
      logic [N-1:0]          s1;
      logic [N-1:0]          s2;
      logic [N-1:0]          s3;
      logic [N-1:0]          level;
      logic [N-1:0][CW-1:0]  cnt;
   } mohc_sync_t;

   mohc_sync_t r;
   mohc_sync_t next_r;

   if (DEB < 2 || N < 1)
   begin : g_bad
      $error("mohc_sync: bad DEB or N");
   end

   always_comb
   begin
      next_r    = r;
      next_r.s1 = pin_n;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < N; i++)
      begin
         // Only stages two and three are compared
         if (r.s2[i] != r.s3[i] || r.s3[i] == r.level[i])
            next_r.cnt[i] = '0;
         else if (r.cnt[i] == CW'(DEB - 1))
         begin
            next_r.level[i] = r.s3[i];
            next_r.cnt[i]   = '0;
         end
         else
            next_r.cnt[i] = r.cnt[i] + CW'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         r.s1    <= '1;
         r.s2    <= '1;
         r.s3    <= '1;
         r.level <= '1;
         r.cnt   <= '0;
      end
      else
         r <= next_r;
   end

   assign outp.asserted = ~r.level;
endmodule // mohc_sync
`default_nettype wire

//--- bench/mohc_props.sv
/*
 Checker on the supervisor ports: stops, pause, feed scaling.
 Assumes a bind into mohc_top.
*/
`timescale 1ns/100ps
`default_nettype none
module mohc_props
   import mohc_pkg::*;
#(
   parameter int SPD_W = 16
)
(
   // Clock and reset
   input wire logic             sys_clk,
   input wire logic             rst,
   // Watched inputs
   input wire logic             estop,
   input wire logic             key_start,
   input wire logic             key_pause,
   input wire logic             key_escape,
   input wire logic             key_reset,
   input wire logic             program_end,
   input wire logic             thread_block,
   input wire logic [SPD_W-1:0] prog_feed,
   input wire logic [SPD_W-1:0] spindle_feed,
   // Watched outputs
   input wire logic [SPD_W-1:0] feed_speed,
   input wire logic [5:0]       run_state,
   input wire logic [3:0]       feed_ovr_step,
   input wire logic             axis_allow,
   input wire logic             spindle_run,
   input wire logic             block_ptr_reset,
   input wire logic             handwheel_mode,
   input wire logic             zero_ovr_prompt
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_estop_stop: assert property (estop |=> run_state == 6'h20)
      else $error("estop not taken");
   a_estop_outputs: assert property (estop [*2] |=> !axis_allow && !spindle_run)
      else $error("motion during estop");
   a_estop_no_start: assert property (
      run_state == 6'h20 && key_start && !key_escape && !key_reset |=> run_state == 6'h20)
      else $error("start left estop");
   a_pause_thread: assert property (
      run_state == 6'h02 && thread_block |=> run_state != 6'h04)
      else $error("pause in thread");
   a_pause_enter: assert property (
      run_state == 6'h02 && key_pause && !thread_block && !estop && !key_escape
      && !key_reset && !program_end |=> run_state == 6'h04)
      else $error("pause not taken");
   a_start_resume: assert property (
      run_state == 6'h04 && key_start && !estop && !key_escape && !key_reset
      |=> run_state == 6'h02)
      else $error("no resume");
   a_escape_first: assert property (
      run_state == 6'h04 && key_escape && !estop |=> run_state == 6'h01 && block_ptr_reset)
      else $error("no rewind");
   a_zero_prompt: assert property (
      run_state == 6'h02 && $past(run_state) == 6'h02 && feed_ovr_step == 4'h0
      && $past(feed_ovr_step) == 4'h0 |-> zero_ovr_prompt)
      else $error("no zero prompt");
   a_axis_gate: assert property (
      axis_allow |-> feed_ovr_step != 4'h0 || $past(feed_ovr_step) != 4'h0)
      else $error("axes at zero override");
   a_feed_scale: assert property (
      !$past(rst) && !$past(thread_block) && !$past(handwheel_mode)
      && $stable(prog_feed) && $stable(feed_ovr_step)
      |-> feed_speed == SPD_W'(32'(prog_feed) * feed_ovr_step * 10 / 100))
      else $error("feed not scaled");
   a_thread_feed: assert property (
      !$past(rst) && $past(thread_block) && $stable(spindle_feed)
      |-> feed_speed == spindle_feed)
      else $error("thread feed wrong");

   cover property (run_state == 6'h04 ##1 run_state == 6'h02);
   cover property (zero_ovr_prompt);
   cover property (block_ptr_reset);
endmodule // mohc_props
`default_nettype wire

//--- bench/mohc_machine.sv
/*
 Machine side: start/pause buttons and three-position knob.
 Assumes pulled-up pins; start, pause and knob input a chatter on each change.
*/
`timescale 1ns/100ps
`default_nettype none
module mohc_machine
(
   // Requests from the bench
   input  wire logic       start_on,
   input  wire logic       pause_on,
   input  wire logic [1:0] knob_pos,
   // Pins, low when closed
   output logic            ext_cycle_start_in_n,
   output logic            ext_cycle_pause_in_n,
   output logic            hold_knob_input_a_n,
   output logic            hold_knob_input_b_n
);
   initial {ext_cycle_start_in_n, ext_cycle_pause_in_n} = 2'h3;
   initial {hold_knob_input_a_n, hold_knob_input_b_n} = 2'h3;
   // Chatter makes the debouncer earn its keep
   always @(start_on)
   begin
      repeat (3)
      begin
         ext_cycle_start_in_n = ~ext_cycle_start_in_n;
         #4;
      end
      ext_cycle_start_in_n = ~start_on;
   end
   always @(pause_on)
   begin
      ext_cycle_pause_in_n = ~ext_cycle_pause_in_n;
      #6;
      ext_cycle_pause_in_n = ~pause_on;
   end
   // Pos 2 closes a, pos 3 closes b
   always @(knob_pos)
   begin
      hold_knob_input_a_n = ~hold_knob_input_a_n;
      #4;
      hold_knob_input_a_n = (knob_pos != 2'h2);
      hold_knob_input_b_n = (knob_pos != 2'h3);
   end
endmodule // mohc_machine
`default_nettype wire

//--- bench/tb_top.sv
/*
 Bench for mohc_top: overrides, stops, knob, external pins.
 Assumes DEB=4, HW_WIN=16; pins settle within 14 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        sys_clk, rst, auto_mode, estop, single_mode, thread_block;
   logic        handwheel_override_enable, handwheel_method_select, hold_knob_enable;
   logic        ext_start_pause_enable, handwheel_cw, start_on, pause_on;
   logic [1:0]  knob_pos, rapid_ovr_code;
   logic [15:0] prog_feed, spindle_feed, axis_z_rapid_speed, axis_x_rapid_speed;
   logic [15:0] axis_y_rapid_speed, feed_speed, rapid_z_speed, rapid_x_speed, rapid_y_speed;
   logic [18:0] pls;
   logic        ext_cycle_start_in_n, ext_cycle_pause_in_n;
   logic        hold_knob_input_a_n, hold_knob_input_b_n;
   logic        axis_allow, block_allow, spindle_run, block_ptr_reset, handwheel_mode;
   logic        zero_ovr_prompt, cycle_stop_armed, ext_alarm;
   logic [5:0]  run_state, last_st;
   logic [3:0]  feed_ovr_step;
   logic [6:0]  handwheel_pct;
   logic [5:0]  exp_q[$];
   logic [15:0] seed;
   int          n_fail = 0, n_tests = 0, fo = 10, ro = 3, i;
   // Knob walk 2,3,2,1
   int          kp[4] = '{2, 3, 2, 1};
   logic [3:0]  ks = 4'b1101, ka = 4'b1000;

   mohc_top #(.DEB(4), .HW_WIN(16)) u_mohc_top (.*,
      .key_start(pls[0]), .key_pause(pls[1]), .key_escape(pls[2]), .key_reset(pls[3]),
      .key_cycle_stop(pls[4]), .key_handwheel(pls[5]), .key_spindle_on(pls[6]),
      .key_spindle_off(pls[7]), .feed_ovr_up(pls[8]), .feed_ovr_down(pls[9]),
      .rapid_ovr_up(pls[10]), .rapid_ovr_down(pls[11]), .handwheel_detent(pls[12]),
      .block_done(pls[13]), .cycle_step_done(pls[14]), .cycle_end_done(pls[15]),
      .program_end(pls[16]), .prog_spindle_on(pls[17]), .prog_spindle_off(pls[18]));
   mohc_machine u_mohc_machine (.*);

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task give_verdict;
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Zero: no state change expected
   task pulse(input int b, input logic [5:0] e = 6'h00);
      if (e != 6'h00)
         exp_q.push_back(e);
      pls[b] = 1'b1;
      tick(1);
      pls[b] = 1'b0;
      tick(1);
   endtask

   always @(negedge sys_clk)
   begin
      if (rst)
         last_st <= 6'h01;
      else if (run_state !== last_st)
      begin
         last_st <= run_state;
         check("run_state", run_state, exp_q.size() > 0 ? exp_q.pop_front() : 6'h3f);
      end
   end

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #100000;
      n_fail++;
      give_verdict();
   end

   initial
   begin
      {pls, auto_mode, estop, single_mode, thread_block, handwheel_override_enable,
         handwheel_method_select, hold_knob_enable, ext_start_pause_enable, handwheel_cw,
         start_on, pause_on} = '0;
      knob_pos = 2'h1;
      rst = 1'b1;
      seed = lfsr(16'h21e5);
      prog_feed = seed & 16'h3fff;
      seed = lfsr(seed);
      axis_z_rapid_speed = seed;
      axis_x_rapid_speed = ~seed;
      axis_y_rapid_speed = seed ^ 16'h5a5a;
      spindle_feed = seed >> 1;
      tick(5);
      rst = 1'b0;
      check("feed_ovr_step", feed_ovr_step, 4'ha);
      check("rapid_ovr_code", rapid_ovr_code, 2'h3);
      for (i = 0; i < 29; i++)
      begin
         pulse(i < 12 ? 9 : 8);
         fo = i < 12 ? (fo > 0 ? fo - 1 : 0) : (fo < 15 ? fo + 1 : 15);
         check("feed_ovr_step", feed_ovr_step, fo);
         check("feed_speed", feed_speed, prog_feed * fo * 10 / 100);
      end
      for (i = 0; i < 9; i++)
      begin
         pulse(i < 5 ? 11 : 10);
         ro = i < 5 ? (ro > 0 ? ro - 1 : 0) : (ro < 3 ? ro + 1 : 3);
         check("rapid_ovr_code", rapid_ovr_code, ro);
         check("rapid_z_speed", rapid_z_speed, axis_z_rapid_speed * (ro + 1) * 25 / 100);
      end
      auto_mode = 1'b1;
      pulse(0, 6'h02);
      repeat (15) pulse(9);
      check("zero_ovr_prompt", zero_ovr_prompt, 1'b1);
      check("axis_allow", axis_allow, 1'b0);
      pulse(8);
      tick(1);
      check("axis_allow", axis_allow, 1'b1);
      thread_block = 1'b1;
      pulse(1);
      check("feed_speed", feed_speed, spindle_feed);
      thread_block = 1'b0;
      pulse(1, 6'h04);
      pulse(0, 6'h02);
      pulse(1, 6'h04);
      exp_q.push_back(6'h01);
      pls[2] = 1'b1;
      tick(1);
      pls[2] = 1'b0;
      check("block_ptr_reset", block_ptr_reset, 1'b1);
      tick(1);
      single_mode = 1'b1;
      pulse(0, 6'h02);
      pulse(13, 6'h08);
      pulse(0, 6'h02);
      pulse(14, 6'h08);
      single_mode = 1'b0;
      pulse(0, 6'h02);
      pulse(4);
      check("cycle_stop_armed", cycle_stop_armed, 1'b1);
      pulse(15, 6'h10);
      pulse(0, 6'h02);
      exp_q.push_back(6'h20);
      estop = 1'b1;
      tick(3);
      pulse(0);
      check("run_state", run_state, 6'h20);
      estop = 1'b0;
      pulse(2, 6'h01);
      hold_knob_enable = 1'b1;
      pulse(0, 6'h02);
      pulse(17);
      pulse(18);
      check("spindle_run", spindle_run, 1'b0);
      pulse(17);
      for (i = 0; i < 4; i++)
      begin
         knob_pos = kp[i];
         tick(14);
         check("spindle_run", spindle_run, ks[i]);
         check("block_allow", block_allow, ks[i]);
         check("axis_allow", axis_allow, ka[i]);
      end
      knob_pos = 2'h3;
      tick(14);
      pulse(2, 6'h01);
      knob_pos = 2'h1;
      tick(14);
      check("spindle_run", spindle_run, 1'b0);
      hold_knob_enable = 1'b0;
      knob_pos = 2'h3;
      tick(14);
      pulse(6);
      check("spindle_run", spindle_run, 1'b1);
      hold_knob_enable = 1'b1;
      tick(2);
      check("spindle_run", spindle_run, 1'b0);
      pulse(7);
      knob_pos = 2'h1;
      ext_start_pause_enable = 1'b1;
      tick(14);
      exp_q.push_back(6'h02);
      start_on = 1'b1;
      tick(14);
      start_on = 1'b0;
      exp_q.push_back(6'h04);
      pause_on = 1'b1;
      tick(14);
      pause_on = 1'b0;
      tick(14);
      pulse(2, 6'h01);
      auto_mode = 1'b0;
      start_on = 1'b1;
      tick(14);
      auto_mode = 1'b1;
      tick(2);
      check("ext_alarm", ext_alarm, 1'b1);
      start_on = 1'b0;
      tick(14);
      pulse(0);
      pulse(3);
      check("ext_alarm", ext_alarm, 1'b0);
      handwheel_override_enable = 1'b1;
      pulse(5);
      check("handwheel_mode", handwheel_mode, 1'b1);
      check("handwheel_pct", handwheel_pct, 7'h00);
      handwheel_cw = 1'b1;
      repeat (3) pulse(12);
      handwheel_cw = 1'b0;
      pulse(12);
      check("handwheel_pct", handwheel_pct, 7'h02);
      pulse(0, 6'h02);
      pulse(16, 6'h01);
      check("handwheel_mode", handwheel_mode, 1'b0);
      tick(2);
      check("exp_q", exp_q.size(), 0);
      give_verdict();
   end
endmodule // tb_top
bind mohc_top mohc_props #(.SPD_W(SPD_W)) u_mohc_props (.*);
`default_nettype wire
